// file: design/cio_consts.svh
`ifndef CIO_CONSTS_SVH
`define CIO_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define CIO_NPORT 5
`define CIO_NPIN 32
`define CIO_NCB 6
`define CIO_CNT_W 16

// ****************************************
// Timing
// ****************************************
`define CIO_MCLK_HZ 200000000
`define CIO_REF_HZ 100000000
`define CIO_REF_DIV (`CIO_MCLK_HZ / `CIO_REF_HZ)

// ****************************************
// Pin sharing
// ****************************************
`define CIO_LINK_MASK 32'hf000_0000
`define CIO_MASK_P0 32'h0000_0001
`define CIO_MASK_P1 32'h0000_000f
`define CIO_MASK_P2 32'h0000_00ff
`define CIO_MASK_P3 32'h0000_ffff
`define CIO_MASK_P4 32'hffff_ffff

// ****************************************
// Address map
// ****************************************
`define CIO_RGN_PORT 4'h0
`define CIO_RGN_CB 4'h1
`define CIO_RGN_GLB 4'h2
`define CIO_OFS_CTRL 5'h00
`define CIO_OFS_COND 5'h04
`define CIO_OFS_TIME 5'h08
`define CIO_OFS_DATA 5'h0c
`define CIO_OFS_COUNT 5'h10
`define CIO_OFS_STAMP 5'h14
`define CIO_OFS_STATUS 5'h18

// ****************************************
// Fields and reset values
// ****************************************
`define CIO_CTRL_EN 0
`define CIO_CTRL_OUT 1
`define CIO_CTRL_OD 2
`define CIO_CTRL_STB 3
`define CIO_CTRL_COND 4
`define CIO_CTRL_TIMED 6
`define CIO_CTRL_CB 8
`define CIO_CTRL_MASK 32'h0000_077f
`define CIO_CTRL_RST 32'h0000_0000
`define CIO_CB_SRC 0
`define CIO_CB_DIV 8
`define CIO_CB_MASK 32'h0000_ff01
`define CIO_STAT_VALID 0
`define CIO_STAT_FULL 1
`define CIO_RESP_OK 2'h0
`define CIO_RESP_ERR 2'h2

`endif

// file: design/cio_pkg.sv
package cio_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		CIO_COND_NONE = 2'h0,
		CIO_COND_EQ = 2'h1,
		CIO_COND_NEQ = 2'h2
	} cio_cond_t;

	typedef logic [31:0] cio_word_t;
	typedef logic [15:0] cio_count_t;

endpackage

// file: design/cio_port.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "cio_consts.svh"
// Contract
// - Ports of widths 1, 4, 8, 16, 32
// - All pins of a port share direction
// - Drive pins or sample, optionally conditional
// - Each port access completes in one cycle
// - Open drain: zero pulls low, one floats
// - Data passes pin register and transfer register
// - 16-bit counter times pin transfers
// - Counter readable; target count delays transfer
// - Counter captured as timestamp per transfer
// - Enabled link disables ports on shared pins
// - Narrower enabled port overrules wider ports
// - Unshared pins stay with wider port
// - Ports transfer only on the pins they own
// - Six clock blocks; block zero reference clock
// - Other clock blocks run at programmable rates
// - Clock block may use 1-bit port clock
// - Port clock source optionally divided
// - Input port honours incoming ready strobe
// - Output port generates strobe with data
// - After reset ports use clock block zero
// - Pin conditions become events to scheduler
module cio_port
	import cio_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// Register bus write
	input wire logic [11:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// Register bus read
	input wire logic [11:0] ARADDR,
	input wire logic [2:0] ARPROT,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Pins
	input wire logic [31:0] PIN_I,
	output logic [31:0] PIN_O,
	output logic [31:0] PIN_OE,
	// Strobes
	input wire logic [4:0] STROBE_IN,
	output logic [4:0] STROBE_OUT,
	// Events
	output logic [4:0] EVENT
);

	// ****************************************
	// Helpers
	// ****************************************
	localparam logic [31:0] LINK_MASK = `CIO_LINK_MASK;
	localparam logic [7:0] REF_LAST = 8'(`CIO_REF_DIV - 1);

	function automatic cio_word_t port_mask(input int k);
		case (k)
			0: port_mask = `CIO_MASK_P0;
			1: port_mask = `CIO_MASK_P1;
			2: port_mask = `CIO_MASK_P2;
			3: port_mask = `CIO_MASK_P3;
			default: port_mask = `CIO_MASK_P4;
		endcase
	endfunction

	function automatic cio_word_t merge(input cio_word_t old, input cio_word_t nw,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				old[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		merge = old;
	endfunction

	function automatic logic cond_met(input logic [1:0] mode, input cio_word_t val,
		input cio_word_t ref_val);
		case (mode)
			CIO_COND_EQ: cond_met = (val == ref_val);
			CIO_COND_NEQ: cond_met = (val != ref_val);
			default: cond_met = 1'b1;
		endcase
	endfunction

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = 1'b0;
		if (a[11:8] == `CIO_RGN_PORT && a[7:5] < 3'(`CIO_NPORT) && a[4:0] <= `CIO_OFS_STATUS
			&& a[1:0] == 2'h0) begin
			addr_ok = 1'b1;
		end
		if (a[11:8] == `CIO_RGN_CB && a[7:5] == 3'h0 && a[4:2] < 3'(`CIO_NCB)
			&& a[1:0] == 2'h0) begin
			addr_ok = 1'b1;
		end
		if (a[11:8] == `CIO_RGN_GLB && a[7:0] == 8'h00) begin
			addr_ok = 1'b1;
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	cio_word_t ctrl_reg [0:`CIO_NPORT-1];
	cio_word_t cond_reg [0:`CIO_NPORT-1];
	cio_count_t target_reg [0:`CIO_NPORT-1];
	cio_word_t xfer_reg [0:`CIO_NPORT-1];
	cio_word_t shift_reg [0:`CIO_NPORT-1];
	cio_count_t count_reg [0:`CIO_NPORT-1];
	cio_count_t stamp_reg [0:`CIO_NPORT-1];
	logic [4:0] valid_reg;
	logic [4:0] full_reg;
	cio_word_t cb_cfg_reg [0:`CIO_NCB-1];
	logic [7:0] cb_cnt_reg [0:`CIO_NCB-1];
	logic [7:0] ref_cnt_reg;
	logic pin0_prev_reg;
	logic link_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [11:0] aw_addr_reg;
	cio_word_t w_data_reg;
	logic [3:0] w_strb_reg;

	logic [5:0] cb_tick;
	logic [5:0] cb_src;
	logic [31:0] own_map [0:`CIO_NPORT-1];
	cio_word_t in_val [0:`CIO_NPORT-1];
	logic [4:0] tick;
	logic [4:0] do_in;
	logic [4:0] do_out;
	logic [4:0] rd_clr;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic [2:0] wr_idx;
	cio_word_t rd_data;

	// ****************************************
	// Clock blocks
	// ****************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ref_cnt_reg <= 8'h00;
			pin0_prev_reg <= 1'b0;
		end else begin
			ref_cnt_reg <= (ref_cnt_reg == REF_LAST) ? 8'h00 : ref_cnt_reg + 8'h01;
			pin0_prev_reg <= PIN_I[0];
		end
	end

	always_comb begin
		cb_src[0] = (ref_cnt_reg == REF_LAST);
		cb_tick[0] = cb_src[0];
		for (int b = 1; b < `CIO_NCB; b++) begin
			cb_src[b] = cb_cfg_reg[b][`CIO_CB_SRC] ? (PIN_I[0] & ~pin0_prev_reg) : cb_src[0];
			cb_tick[b] = cb_src[b] && (cb_cnt_reg[b] == cb_cfg_reg[b][`CIO_CB_DIV +: 8]);
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int b = 0; b < `CIO_NCB; b++) begin
				cb_cnt_reg[b] <= 8'h00;
			end
		end else begin
			for (int b = 1; b < `CIO_NCB; b++) begin
				if (cb_tick[b]) begin
					cb_cnt_reg[b] <= 8'h00;
				end else if (cb_src[b]) begin
					cb_cnt_reg[b] <= cb_cnt_reg[b] + 8'h01;
				end
			end
		end
	end

	// ****************************************
	// Pin ownership and transfer conditions
	// ****************************************
	always_comb begin
		int sel;
		cio_word_t m;
		sel = -1;
		m = '0;
		for (int k = 0; k < `CIO_NPORT; k++) begin
			own_map[k] = '0;
		end
		for (int p = 0; p < `CIO_NPIN; p++) begin
			sel = -1;
			for (int k = `CIO_NPORT - 1; k >= 0; k--) begin
				m = port_mask(k);
				if (ctrl_reg[k][`CIO_CTRL_EN] && m[p]) begin
					sel = k;
				end
			end
			if (sel >= 0 && !(link_reg && LINK_MASK[p])) begin
				own_map[sel][p] = 1'b1;
			end
		end
		for (int k = 0; k < `CIO_NPORT; k++) begin
			tick[k] = (ctrl_reg[k][`CIO_CTRL_CB +: 3] < 3'(`CIO_NCB))
				? cb_tick[ctrl_reg[k][`CIO_CTRL_CB +: 3]] : 1'b0;
			in_val[k] = PIN_I & own_map[k];
			do_in[k] = ctrl_reg[k][`CIO_CTRL_EN] && !ctrl_reg[k][`CIO_CTRL_OUT] && tick[k]
				&& (!ctrl_reg[k][`CIO_CTRL_TIMED] || count_reg[k] == target_reg[k])
				&& cond_met(ctrl_reg[k][`CIO_CTRL_COND +: 2], in_val[k], cond_reg[k])
				&& (!ctrl_reg[k][`CIO_CTRL_STB] || STROBE_IN[k]);
			do_out[k] = ctrl_reg[k][`CIO_CTRL_EN] && ctrl_reg[k][`CIO_CTRL_OUT] && tick[k]
				&& full_reg[k]
				&& (!ctrl_reg[k][`CIO_CTRL_TIMED] || count_reg[k] == target_reg[k]);
		end
	end

	// ****************************************
	// Bus handshake
	// ****************************************
	assign aw_take = AWVALID & AWREADY;
	assign w_take = WVALID & WREADY;
	assign ar_take = ARVALID & ARREADY;
	assign do_write = aw_full_reg & w_full_reg & ~BVALID;
	assign wr_idx = aw_addr_reg[7:5];

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= `CIO_RESP_OK;
		end else begin
			aw_full_reg <= (aw_full_reg | aw_take) & ~do_write;
			w_full_reg <= (w_full_reg | w_take) & ~do_write;
			AWREADY <= ~((aw_full_reg | aw_take) & ~do_write);
			WREADY <= ~((w_full_reg | w_take) & ~do_write);
			if (aw_take) begin
				aw_addr_reg <= AWADDR;
			end
			if (w_take) begin
				w_data_reg <= WDATA;
				w_strb_reg <= WSTRB;
			end
			if (do_write) begin
				BVALID <= 1'b1;
				BRESP <= addr_ok(aw_addr_reg) ? `CIO_RESP_OK : `CIO_RESP_ERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		for (int k = 0; k < `CIO_NPORT; k++) begin
			rd_clr[k] = ar_take && ARADDR[11:8] == `CIO_RGN_PORT && ARADDR[7:5] == 3'(k)
				&& ARADDR[4:0] == `CIO_OFS_DATA;
		end
		if (ARADDR[11:8] == `CIO_RGN_PORT && ARADDR[7:5] < 3'(`CIO_NPORT)) begin
			case (ARADDR[4:0])
				`CIO_OFS_CTRL: rd_data = ctrl_reg[ARADDR[7:5]];
				`CIO_OFS_COND: rd_data = cond_reg[ARADDR[7:5]];
				`CIO_OFS_TIME: rd_data = {16'h0000, target_reg[ARADDR[7:5]]};
				`CIO_OFS_DATA: rd_data = xfer_reg[ARADDR[7:5]];
				`CIO_OFS_COUNT: rd_data = {16'h0000, count_reg[ARADDR[7:5]]};
				`CIO_OFS_STAMP: rd_data = {16'h0000, stamp_reg[ARADDR[7:5]]};
				`CIO_OFS_STATUS: rd_data = {30'h0, full_reg[ARADDR[7:5]], valid_reg[ARADDR[7:5]]};
				default: rd_data = 32'h0000_0000;
			endcase
		end else if (ARADDR[11:8] == `CIO_RGN_CB && ARADDR[7:5] == 3'h0
			&& ARADDR[4:2] < 3'(`CIO_NCB)) begin
			rd_data = cb_cfg_reg[ARADDR[4:2]];
		end else if (ARADDR[11:8] == `CIO_RGN_GLB) begin
			rd_data = {31'h0, link_reg};
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `CIO_RESP_OK;
		end else begin
			ARREADY <= ~ar_take & ~(RVALID & ~RREADY);
			if (ar_take) begin
				RVALID <= 1'b1;
				RDATA <= addr_ok(ARADDR) ? rd_data : 32'h0000_0000;
				RRESP <= addr_ok(ARADDR) ? `CIO_RESP_OK : `CIO_RESP_ERR;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				ctrl_reg[k] <= `CIO_CTRL_RST;
				cond_reg[k] <= 32'h0000_0000;
				target_reg[k] <= 16'h0000;
			end
			for (int b = 0; b < `CIO_NCB; b++) begin
				cb_cfg_reg[b] <= 32'h0000_0000;
			end
			link_reg <= 1'b0;
		end else begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				if (do_in[k] || do_out[k]) begin
					ctrl_reg[k][`CIO_CTRL_TIMED] <= 1'b0;
				end
				if (do_write && aw_addr_reg[11:8] == `CIO_RGN_PORT && wr_idx == 3'(k)) begin
					case (aw_addr_reg[4:0])
						`CIO_OFS_CTRL: ctrl_reg[k] <= merge(ctrl_reg[k], w_data_reg, w_strb_reg)
							& `CIO_CTRL_MASK;
						`CIO_OFS_COND: cond_reg[k] <= merge(cond_reg[k], w_data_reg, w_strb_reg)
							& port_mask(k);
						`CIO_OFS_TIME: target_reg[k] <= 16'(merge({16'h0000, target_reg[k]},
							w_data_reg, w_strb_reg));
						default: ;
					endcase
				end
			end
			if (do_write && aw_addr_reg[11:8] == `CIO_RGN_CB && aw_addr_reg[7:5] == 3'h0
				&& aw_addr_reg[4:2] != 3'h0 && aw_addr_reg[4:2] < 3'(`CIO_NCB)) begin
				cb_cfg_reg[aw_addr_reg[4:2]] <= merge(cb_cfg_reg[aw_addr_reg[4:2]],
					w_data_reg, w_strb_reg) & `CIO_CB_MASK;
			end
			if (do_write && aw_addr_reg[11:8] == `CIO_RGN_GLB && aw_addr_reg[7:0] == 8'h00
				&& w_strb_reg[0]) begin
				link_reg <= w_data_reg[0];
			end
		end
	end

	// ****************************************
	// Data path
	// ****************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				xfer_reg[k] <= 32'h0000_0000;
				shift_reg[k] <= 32'h0000_0000;
			end
			valid_reg <= 5'h00;
			full_reg <= 5'h00;
		end else begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				if (rd_clr[k]) begin
					valid_reg[k] <= 1'b0;
				end
				if (do_out[k]) begin
					shift_reg[k] <= xfer_reg[k];
					full_reg[k] <= 1'b0;
				end
				if (do_in[k]) begin
					shift_reg[k] <= in_val[k];
					xfer_reg[k] <= in_val[k] & port_mask(k);
					valid_reg[k] <= 1'b1;
				end else if (do_write && aw_addr_reg[11:8] == `CIO_RGN_PORT && wr_idx == 3'(k)
					&& aw_addr_reg[4:0] == `CIO_OFS_DATA && ctrl_reg[k][`CIO_CTRL_OUT]) begin
					xfer_reg[k] <= merge(xfer_reg[k], w_data_reg, w_strb_reg) & port_mask(k);
					full_reg[k] <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Counters and timestamps
	// ****************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				count_reg[k] <= 16'h0000;
				stamp_reg[k] <= 16'h0000;
			end
		end else begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				if (tick[k]) begin
					count_reg[k] <= count_reg[k] + 16'h0001;
				end
				if (do_in[k] || do_out[k]) begin
					stamp_reg[k] <= count_reg[k];
				end
			end
		end
	end

	// ****************************************
	// Pins, strobes and events
	// ****************************************
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			PIN_O <= 32'h0000_0000;
			PIN_OE <= 32'h0000_0000;
		end else begin
			for (int p = 0; p < `CIO_NPIN; p++) begin
				PIN_O[p] <= 1'b0;
				PIN_OE[p] <= 1'b0;
				for (int k = 0; k < `CIO_NPORT; k++) begin
					if (own_map[k][p] && ctrl_reg[k][`CIO_CTRL_OUT]) begin
						if (ctrl_reg[k][`CIO_CTRL_OD]) begin
							PIN_OE[p] <= ~shift_reg[k][p];
						end else begin
							PIN_O[p] <= shift_reg[k][p];
							PIN_OE[p] <= 1'b1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			STROBE_OUT <= 5'h00;
			EVENT <= 5'h00;
		end else begin
			for (int k = 0; k < `CIO_NPORT; k++) begin
				if (do_out[k]) begin
					STROBE_OUT[k] <= ctrl_reg[k][`CIO_CTRL_STB];
				end else if (tick[k] || !ctrl_reg[k][`CIO_CTRL_EN]) begin
					STROBE_OUT[k] <= 1'b0;
				end
				EVENT[k] <= do_in[k];
			end
		end
	end

endmodule

// file: tb/cio_port_sva.sv
`timescale 1ns/10ps
`include "cio_consts.svh"
module cio_port_sva (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// Register bus
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY,
	// Events
	input wire logic [4:0] EVENT
);
	// ********
	// Checks
	// ********
	default clocking mck @(posedge MCLK);
	endclocking
	default disable iff (RST);

	a_wr_answer_time: assert property (
		AWVALID && AWREADY && WVALID && WREADY && !BVALID |=> !BVALID ##1 BVALID
	) else $error("write answer not two edges after handshake");
	a_bresp_held: assert property (
		BVALID && !BREADY |=> BVALID && $stable(BRESP)
	) else $error("write answer dropped early");
	a_rd_answer_time: assert property (
		ARVALID && ARREADY |=> RVALID
	) else $error("read answer late");
	a_rdata_held: assert property (
		RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP)
	) else $error("read answer dropped early");
	a_ar_blocked: assert property (
		RVALID |-> !ARREADY
	) else $error("read taken while answer pending");
	a_err_data_zero: assert property (
		RVALID && RRESP == `CIO_RESP_ERR |-> RDATA == 32'h0
	) else $error("error read carries data");
	a_event_single: assert property (
		(EVENT & $past(EVENT)) == 5'h0
	) else $error("event longer than one cycle");
	a_aw_taken_drop: assert property (
		AWVALID && AWREADY && WVALID && WREADY && !BVALID |=> !AWREADY ##1 AWREADY
	) else $error("write address ready not back after the write");
endmodule

bind cio_port cio_port_sva u_sva (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
	.BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
	.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .EVENT(EVENT));

// file: tb/cio_pin_model.sv
`timescale 1ns/10ps
module cio_pin_model (
	// Clock
	input wire logic mclk,
	// Device pins
	input wire logic [31:0] pin_o,
	input wire logic [31:0] pin_oe,
	output logic [31:0] pin_i,
	// Bench controls
	input wire logic [31:0] drv,
	input wire logic drv_en,
	input wire logic clk_en,
	input wire logic [4:0] stb,
	output logic [4:0] strobe_in
);
	logic [1:0] ph_reg;
	logic ck_reg;
	logic [31:0] lvl;

	// Application clock on pin 0, still when off
	always_ff @(posedge mclk) begin
		if (!clk_en) begin
			ph_reg <= 2'h0;
			ck_reg <= 1'b0;
		end else if (ph_reg == 2'h2) begin
			ph_reg <= 2'h0;
			ck_reg <= !ck_reg;
		end else begin
			ph_reg <= ph_reg + 2'h1;
		end
	end

	// Device drive wins, then model, else pull-down
	assign lvl = (pin_oe & pin_o) | (~pin_oe & (drv_en ? drv : 32'h0));
	assign pin_i = {lvl[31:1], clk_en ? ck_reg : lvl[0]};
	assign strobe_in = stb;
endmodule

// file: tb/tb_cio_port.sv
`timescale 1ns/10ps
`include "cio_consts.svh"
module tb_cio_port
	import cio_pkg::*;
;
	// ********
	// Signals
	// ********
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] drv = 32'h0;
	logic drv_en = 1'b0;
	logic clk_en = 1'b0;
	logic [4:0] stb = 5'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, pin_i, pin_o, pin_oe;
	logic [4:0] strobe_in, strobe_out, ev;
	int n_mismatch = 0;
	int tests_run = 0;
	cio_word_t d, x, y, v;
	logic [15:0] c;
	int n, g;

	always #2.5 mclk = ~mclk;

	cio_port dut (.MCLK(mclk), .RST(rst), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
		.STROBE_IN(strobe_in), .STROBE_OUT(strobe_out), .EVENT(ev));
	cio_pin_model far (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
		.drv(drv), .drv_en(drv_en), .clk_en(clk_en), .stb(stb), .strobe_in(strobe_in));

	// ********
	// Helpers
	// ********
	function automatic cio_word_t lfsr(input cio_word_t s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [11:0] pa(input int k, input logic [4:0] o);
		return 12'(k * 32) + 12'(o);
	endfunction

	function automatic logic [1:0] rexp(input logic [11:0] a);
		if (a[1:0] != 2'h0) return `CIO_RESP_ERR;
		if (a < 12'h0a0 && a[4:0] <= `CIO_OFS_STATUS) return `CIO_RESP_OK;
		if ((a >= 12'h100 && a <= 12'h114) || a == 12'h200) return `CIO_RESP_OK;
		return `CIO_RESP_ERR;
	endfunction

	task automatic print_verdict();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input cio_word_t got, input cio_word_t exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tmo(input int k);
		if (k >= 400) begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [11:0] a, input cio_word_t dv);
		bit pa_p, pw_p;
		int k;
		pa_p = 1;
		pw_p = 1;
		k = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while ((pa_p || pw_p) && k < 400) begin
			@(posedge mclk);
			k++;
			if (pa_p && awready === 1'b1) begin
				pa_p = 0;
				awvalid <= 1'b0;
			end
			if (pw_p && wready === 1'b1) begin
				pw_p = 0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1 && k < 400) begin
			@(posedge mclk);
			k++;
		end
		tmo(k);
		chk(bresp, rexp(a));
		bready <= 1'b1;
		@(posedge mclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output cio_word_t dv);
		int k;
		k = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		while (k == 0 || (arready !== 1'b1 && k < 400)) begin
			@(posedge mclk);
			k++;
		end
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && k < 400) begin
			@(posedge mclk);
			k++;
		end
		tmo(k);
		dv = rdata;
		chk(rresp, rexp(a));
		rready <= 1'b1;
		@(posedge mclk);
		rready <= 1'b0;
	endtask

	task automatic settle(input cio_word_t m, input cio_word_t oe, input cio_word_t o);
		int k;
		k = 0;
		while (((pin_oe & m) !== oe || (pin_o & m & oe) !== o) && k < 60) begin
			@(posedge mclk);
			k++;
		end
		chk(pin_oe & m, oe);
		chk(pin_o & m & oe, o);
	endtask

	task automatic wsig(input bit s, input int k, input int lim, output int cnt);
		cnt = 0;
		while ((s ? strobe_out[k] : ev[k]) !== 1'b1 && cnt < lim) begin
			@(posedge mclk);
			cnt++;
		end
	endtask

	task automatic gap(input int k, output int cnt);
		int m;
		wsig(0, k, 400, m);
		tmo(m);
		@(posedge mclk);
		wsig(0, k, 400, cnt);
		tmo(cnt);
	endtask

	// ********
	// Sequence
	// ********
	initial begin
		x = 32'h51aa7336;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			rd(pa(k, `CIO_OFS_CTRL), d);
			chk(d, `CIO_CTRL_RST);
		end
		wr(12'h100, 32'hff01);
		rd(12'h100, d);
		chk(d, 32'h0);
		rd(12'h300, d);
		chk(d, 32'h0);
		wr(12'h01c, 32'h1);
		wr(12'h006, 32'h1);
		wr(pa(4, `CIO_OFS_CTRL), 32'h3);
		for (int i = 0; i < 3; i++) begin
			x = lfsr(x);
			wr(pa(4, `CIO_OFS_DATA), x);
			settle(32'hffff_ffff, 32'hffff_ffff, x);
		end
		rd(pa(4, `CIO_OFS_STATUS), d);
		chk(d, 32'h0);
		y = lfsr(x);
		wr(pa(1, `CIO_OFS_CTRL), 32'h3);
		wr(pa(1, `CIO_OFS_DATA), y);
		settle(32'hffff_ffff, 32'hffff_ffff, {x[31:4], y[3:0]});
		wr(12'h200, 32'h1);
		settle(32'hffff_ffff, 32'h0fff_ffff, {4'h0, x[27:4], y[3:0]});
		wr(12'h200, 32'h0);
		wr(pa(1, `CIO_OFS_CTRL), 32'h0);
		v = lfsr(y);
		wr(pa(2, `CIO_OFS_CTRL), 32'h7);
		wr(pa(2, `CIO_OFS_DATA), v);
		settle(32'hff, {24'h0, ~v[7:0]}, 32'h0);
		settle(32'hffff_ff00, 32'hffff_ff00, {x[31:8], 8'h0});
		wr(pa(2, `CIO_OFS_CTRL), 32'hb);
		wr(pa(2, `CIO_OFS_DATA), y);
		wsig(1, 2, 400, n);
		tmo(n);
		chk(strobe_out[2], 1'b1);
		wr(pa(2, `CIO_OFS_CTRL), 32'h0);
		wr(pa(4, `CIO_OFS_CTRL), 32'h0);
		drv <= v;
		drv_en <= 1'b1;
		stb <= 5'h8;
		rd(pa(3, `CIO_OFS_COUNT), d);
		c = d[15:0] + 16'h0064;
		wr(pa(3, `CIO_OFS_TIME), {16'h0, c});
		wr(pa(3, `CIO_OFS_CTRL), 32'h49);
		wsig(0, 3, 400, n);
		tmo(n);
		stb <= 5'h0;
		rd(pa(3, `CIO_OFS_STAMP), d);
		chk(d, {16'h0, c});
		rd(pa(3, `CIO_OFS_DATA), d);
		chk(d, {16'h0, v[15:0]});
		rd(pa(3, `CIO_OFS_CTRL), d);
		chk(d, 32'h9);
		chk(pin_oe & 32'hffff, 32'h0);
		stb <= 5'h8;
		gap(3, g);
		chk(g + 1, 2);
		clk_en <= 1'b1;
		wr(pa(3, `CIO_OFS_CTRL), 32'h101);
		for (int dv = 0; dv < 3; dv += 2) begin
			wr(12'h104, {16'h0, 8'(dv), 8'h1});
			rd(12'h104, d);
			chk(d, {16'h0, 8'(dv), 8'h1});
			gap(3, g);
			chk(g + 1, 6 * (dv + 1));
		end
		clk_en <= 1'b0;
		wr(pa(3, `CIO_OFS_CTRL), 32'h0);
		drv <= 32'h0;
		wr(pa(0, `CIO_OFS_COND), 32'h1);
		wr(pa(0, `CIO_OFS_CTRL), 32'h11);
		wsig(0, 0, 40, n);
		chk(n, 40);
		drv <= 32'h1;
		wsig(0, 0, 400, n);
		tmo(n);
		chk(n < 20, 1'b1);
		wr(pa(1, `CIO_OFS_CTRL), 32'h9);
		wsig(0, 1, 40, n);
		chk(n, 40);
		stb <= 5'h2;
		wsig(0, 1, 400, n);
		tmo(n);
		chk(n < 20, 1'b1);
		wr(pa(0, `CIO_OFS_CTRL), 32'h21);
		wsig(0, 0, 40, n);
		chk(n, 40);
		drv <= 32'h0;
		wsig(0, 0, 400, n);
		tmo(n);
		chk(n < 20, 1'b1);
		print_verdict();
	end
endmodule
